// File: hdl/gpt_defines.svh
// offsets, reset values and prescaler constants of the timer unit
// How it works
// - five 16-bit timers in two groups; timers chain within a group.
// - each first-group timer selects timer, gated, counter or encoder mode.
// - first-group timer mode counts cpu clock over 8 shifted by 3-bit select.
// - counter mode advances on chosen edges of the timer input pin.
// - gated mode counts prescaled ticks only while the pin is at gate level.
// - encoder mode takes A and B pins and derives count and direction.
// - first core timer flips its toggle latch on each wrap; latch may drive a pin.
// - first core toggle latch can clock either first-group aux timer.
// - first-group aux timers may act as reload or capture for the core.
// - both second-group timers run from prescaled cpu clock or external pins.
// - second-group prescaler is 4 shifted by the 3-bit select.
// - software sets direction; the direction pin may alter it live.
// - second core timer flips its latch on wrap; latch clocks aux or a pin.
// - second core wrap may reload it from capture register; also feeds capture/compare unit.
// - chosen edge on capture pin latches second aux timer into capture register.
// - optionally second aux timer clears right after its capture.
// - capture may instead trigger on first core input pin, direction pin or both.
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH

`define GPT_ADDR_CTRL 4'h0
`define GPT_ADDR_COUNT 4'h5
`define GPT_ADDR_CAPCTL 4'ha
`define GPT_ADDR_CAPTURE_RELOAD 4'hb
`define GPT_ADDR_STATUS 4'hc

`define GPT_CTRL_RST 16'h0000
`define GPT_CAPCTL_RST 16'h0000
`define GPT_COUNT_RST 16'h0000

`define GPT_PRE_A_BASE 11'h008
`define GPT_PRE_B_BASE 11'h004

`endif

// File: hdl/gpt_pkg.sv
// types of the timer unit
package gpt_pkg;

  typedef enum logic [2:0] {
    GPT_TIMER,
    GPT_GATED,
    GPT_COUNTER,
    GPT_INCR,
    GPT_RELOAD,
    GPT_CAPT
  } gpt_mode_t;

  typedef struct packed {
    logic [1:0] spare;
    logic tog_en;
    logic latch_clk;
    logic gate_lvl;
    logic [1:0] edge_sel;
    logic ext_dir;
    logic down;
    logic run;
    gpt_mode_t mode;
    logic [2:0] presc_sel;
  } gpt_ctrl_t;

  typedef struct packed {
    logic [9:0] spare;
    logic rel;
    logic [1:0] src;
    logic clr;
    logic [1:0] edge_sel;
  } gpt_capctl_t;

endpackage

// File: hdl/gpt_timer.sv
// one 16-bit up/down timer cell with load, clear and reload
`timescale 1ns/100ps
`default_nettype none
module gpt_timer #(
  parameter int WIDTH = 16
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_step,
  input wire logic i_down,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_val,
  input wire logic i_clr,
  input wire logic i_rel_en,
  input wire logic [WIDTH-1:0] i_rel_val,
  output logic [WIDTH-1:0] o_value,
  output logic o_ovf
);
  logic [WIDTH-1:0] next_value;
  wire logic wrap = i_down ? (o_value == '0) : (&o_value);

  assign o_ovf = i_step && wrap && !i_load && !i_clr;

  // load beats clear beats reload beats step
  always_comb
  begin
    if (i_load)
      next_value = i_load_val;
    else if (i_clr)
      next_value = '0;
    else if (o_ovf && i_rel_en)
      next_value = i_rel_val;
    else if (i_step)
      next_value = i_down ? o_value - 1'b1 : o_value + 1'b1;
    else
      next_value = o_value;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_value <= '0;
    else
      o_value <= next_value;
  end
endmodule
`default_nettype wire

// File: hdl/gpt_unit.sv
// general purpose timer unit: two timer groups, capture register, registers
`timescale 1ns/100ps
`default_nettype none
`include "gpt_defines.svh"
module gpt_unit (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic [4:0] i_timer_input_pin,
  input wire logic [4:0] i_direction_input_pin,
  input wire logic i_capture_input_pin,
  output logic o_toggle_output_pin,
  output logic o_core_b_toggle_pin,
  output logic o_core_b_ovf,
  output logic [5:0] o_irq
);
  import gpt_pkg::*;

  // ------------------------------------------
  // timer order: 0 aux_a, 1 core_a, 2 aux_b, 3 aux_c, 4 core_b
  // ------------------------------------------
  gpt_ctrl_t ctrl [5];
  gpt_capctl_t capctl;
  logic [15:0] capture_reload_register;
  logic [9:0] presc;
  logic core_a_latch;
  logic core_b_latch;
  logic core_a_latch_q;
  logic core_b_latch_q;
  logic [10:0] pin_s1;
  logic [10:0] pin_s2;
  logic [10:0] pin_s3;
  logic [15:0] val [5];
  logic [15:0] ld_val [5];
  logic [15:0] rel_val [5];
  logic [15:0] rd_tab [16];
  logic [4:0] evt;
  logic [4:0] dn;
  logic [4:0] ld;
  logic [4:0] clr;
  logic [4:0] rel_en;
  logic [4:0] ovf;
  logic [4:0] sw_ld;

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = (sel[0] && r) || (sel[1] && f);
  endfunction

  // ------------------------------------------
  // pin synchronisers and edge detect
  // ------------------------------------------
  // bits 0..4 timer inputs, 5..9 direction inputs, 10 capture input
  wire logic [10:0] pin_raw = {i_capture_input_pin, i_direction_input_pin, i_timer_input_pin};
  wire logic [10:0] pin_rise = pin_s2 & ~pin_s3;
  wire logic [10:0] pin_fall = ~pin_s2 & pin_s3;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pin_s1 <= 11'h000;
      pin_s2 <= 11'h000;
      pin_s3 <= 11'h000;
    end
    else
    begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // ------------------------------------------
  // shared prescaler
  // ------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      presc <= 10'h000;
    else
      presc <= presc + 10'h001;
  end

  // ------------------------------------------
  // five timers
  // ------------------------------------------
  for (genvar i = 0; i < 5; i++)
  begin : g_tmr
    localparam bit GRP_B = (i >= 3);
    localparam bit AUX = (i == 0) || (i == 2) || (i == 3);
    logic raw_evt;
    wire logic [10:0] base = GRP_B ? `GPT_PRE_B_BASE : `GPT_PRE_A_BASE;
    wire logic [10:0] mask = 11'((base << ctrl[i].presc_sel) - 11'h001);
    wire logic tick = (presc & mask[9:0]) == mask[9:0];
    wire logic lat = (i == 3) ? core_b_latch : core_a_latch;
    wire logic lat_q = (i == 3) ? core_b_latch_q : core_a_latch_q;
    wire logic pin_e = edge_hit(ctrl[i].edge_sel, pin_rise[i], pin_fall[i]);
    wire logic lat_e = edge_hit(ctrl[i].edge_sel, lat && !lat_q, !lat && lat_q);
    wire logic a_e = pin_rise[i] || pin_fall[i];
    wire logic quad = a_e || pin_rise[i+5] || pin_fall[i+5];
    // A leading B counts up
    wire logic quad_dn = a_e ? (pin_s2[i] == pin_s2[i+5]) : (pin_s2[i] != pin_s2[i+5]);

    always_comb
    begin
      unique case (ctrl[i].mode)
        GPT_TIMER: raw_evt = tick;
        GPT_GATED: raw_evt = tick && (pin_s2[i] == ctrl[i].gate_lvl);
        GPT_COUNTER: raw_evt = (AUX && ctrl[i].latch_clk) ? lat_e : pin_e;
        GPT_INCR: raw_evt = !GRP_B && quad;
        default: raw_evt = 1'b0;
      endcase
    end

    assign evt[i] = ctrl[i].run && raw_evt;
    assign dn[i] = (ctrl[i].mode == GPT_INCR) ? (quad_dn ^ ctrl[i].down)
                 : (ctrl[i].down ^ (ctrl[i].ext_dir && pin_s2[i+5]));
    assign sw_ld[i] = i_wr && (i_addr == `GPT_ADDR_COUNT + 4'(i));
    assign rd_tab[i] = ctrl[i];
    assign rd_tab[i+5] = val[i];

    gpt_timer #(.WIDTH(16)) u_tmr (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_step(evt[i]),
      .i_down(dn[i]),
      .i_load(ld[i]),
      .i_load_val(ld_val[i]),
      .i_clr(clr[i]),
      .i_rel_en(rel_en[i]),
      .i_rel_val(rel_val[i]),
      .o_value(val[i]),
      .o_ovf(ovf[i])
    );
  end

  // ------------------------------------------
  // aux reload / capture for core_a
  // ------------------------------------------
  wire logic cap_a0 = (ctrl[0].mode == GPT_CAPT)
                    && edge_hit(ctrl[0].edge_sel, pin_rise[0], pin_fall[0]);
  wire logic cap_a2 = (ctrl[2].mode == GPT_CAPT)
                    && edge_hit(ctrl[2].edge_sel, pin_rise[2], pin_fall[2]);
  wire logic rel_a0 = ctrl[0].mode == GPT_RELOAD;
  wire logic rel_a2 = ctrl[2].mode == GPT_RELOAD;

  // ------------------------------------------
  // capture register trigger
  // ------------------------------------------
  wire logic cap_pin_e = edge_hit(capctl.edge_sel, pin_rise[10], pin_fall[10]);
  wire logic cap_in_e = edge_hit(capctl.edge_sel, pin_rise[1], pin_fall[1]);
  wire logic cap_dir_e = edge_hit(capctl.edge_sel, pin_rise[6], pin_fall[6]);
  wire logic cap_evt = (capctl.src == 2'h0) ? cap_pin_e
                     : ((capctl.src[0] && cap_in_e) || (capctl.src[1] && cap_dir_e));

  assign ld[0] = sw_ld[0] || cap_a0;
  assign ld[1] = sw_ld[1];
  assign ld[2] = sw_ld[2] || cap_a2;
  assign ld[3] = sw_ld[3];
  assign ld[4] = sw_ld[4];
  assign ld_val[0] = cap_a0 ? val[1] : i_wdata;
  assign ld_val[1] = i_wdata;
  assign ld_val[2] = cap_a2 ? val[1] : i_wdata;
  assign ld_val[3] = i_wdata;
  assign ld_val[4] = i_wdata;
  assign clr = {1'b0, cap_evt && capctl.clr, 3'b000};
  assign rel_en = {capctl.rel, 2'b00, rel_a0 || rel_a2, 1'b0};
  assign rel_val[0] = 16'h0000;
  assign rel_val[1] = rel_a0 ? val[0] : val[2];
  assign rel_val[2] = 16'h0000;
  assign rel_val[3] = 16'h0000;
  assign rel_val[4] = capture_reload_register;

  // ------------------------------------------
  // register file
  // ------------------------------------------
  wire logic wr_capctl = i_wr && (i_addr == `GPT_ADDR_CAPCTL);
  wire logic wr_capture_reload = i_wr && (i_addr == `GPT_ADDR_CAPTURE_RELOAD);

  assign rd_tab[10] = capctl;
  assign rd_tab[11] = capture_reload_register;
  assign rd_tab[12] = {14'h0000, core_b_latch, core_a_latch};
  assign rd_tab[13] = 16'h0000;
  assign rd_tab[14] = 16'h0000;
  assign rd_tab[15] = 16'h0000;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < 5; k++)
        ctrl[k] <= gpt_ctrl_t'(`GPT_CTRL_RST);
      capctl <= gpt_capctl_t'(`GPT_CAPCTL_RST);
    end
    else
    begin
      for (int k = 0; k < 5; k++)
        if (i_wr && (i_addr == `GPT_ADDR_CTRL + 4'(k)))
          ctrl[k] <= gpt_ctrl_t'(i_wdata);
      if (wr_capctl)
        capctl <= gpt_capctl_t'(i_wdata);
    end
  end

  // hardware capture wins over a software write
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      capture_reload_register <= `GPT_COUNT_RST;
    else if (cap_evt)
      capture_reload_register <= val[3];
    else if (wr_capture_reload)
      capture_reload_register <= i_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= 16'h0000;
    else
      o_rdata <= i_rd ? rd_tab[i_addr] : 16'h0000;
  end

  // ------------------------------------------
  // toggle latches and outputs
  // ------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      core_a_latch <= 1'b0;
      core_b_latch <= 1'b0;
      core_a_latch_q <= 1'b0;
      core_b_latch_q <= 1'b0;
    end
    else
    begin
      core_a_latch <= core_a_latch ^ ovf[1];
      core_b_latch <= core_b_latch ^ ovf[4];
      core_a_latch_q <= core_a_latch;
      core_b_latch_q <= core_b_latch;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_toggle_output_pin <= 1'b0;
      o_core_b_toggle_pin <= 1'b0;
      o_core_b_ovf <= 1'b0;
      o_irq <= 6'h00;
    end
    else
    begin
      o_toggle_output_pin <= core_a_latch && ctrl[1].tog_en;
      o_core_b_toggle_pin <= core_b_latch && ctrl[4].tog_en;
      o_core_b_ovf <= ovf[4];
      o_irq <= {cap_evt, ovf};
    end
  end

  // ------------------------------------------
  // assertions
  // ------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_cap_clr;
    cap_evt && capctl.clr && !sw_ld[3];
  endsequence

  sequence s_val3_zero;
    val[3] == 16'h0000;
  endsequence

  a_core_a_latch: assert property (ovf[1] |=> core_a_latch != $past(core_a_latch))
    else $error("core_a latch did not toggle on wrap");
  a_core_b_latch: assert property (ovf[4] |=> o_core_b_ovf
    ##1 core_b_latch_q != $past(core_b_latch_q, 2))
    else $error("core_b latch or wrap pulse wrong");
  a_capture_value: assert property (cap_evt
    |=> capture_reload_register == $past(val[3]))
    else $error("capture register missed aux_c value");
  a_clear_after: assert property (s_cap_clr |=> s_val3_zero)
    else $error("aux_c not cleared after capture");
  a_reload_core_b: assert property (ovf[4] && capctl.rel && !sw_ld[4]
    |=> val[4] == $past(capture_reload_register))
    else $error("core_b not reloaded from capture register");
  a_gate_hold: assert property (ctrl[1].mode == GPT_GATED && pin_s2[1] != ctrl[1].gate_lvl
    && !ld[1] |=> $stable(val[1]))
    else $error("gated core_a counted while gate closed");
  a_prescale_a: assert property (evt[1] && ctrl[1].mode == GPT_TIMER |-> presc[2:0] == 3'h7)
    else $error("group a tick off prescale grid");
  a_prescale_b: assert property (evt[4] && ctrl[4].mode == GPT_TIMER |-> presc[1:0] == 2'h3)
    else $error("group b tick off prescale grid");
  a_step_up: assert property (evt[1] && !dn[1] && !ld[1] && !ovf[1]
    |=> val[1] == $past(val[1]) + 16'h0001)
    else $error("core_a up step wrong");
  a_capture_irq: assert property (cap_evt |=> o_irq[5] ##1 !o_irq[5] || $past(cap_evt))
    else $error("capture request missing");
endmodule
`default_nettype wire

// File: tb/gpt_pin_model.sv
// pin-side model of the timer unit: drives timer, direction and capture pins
`timescale 1ns/100ps
`default_nettype none
module gpt_pin_model (
  input wire logic i_clk,
  output logic [4:0] o_tin,
  output logic [4:0] o_dir,
  output logic o_cap
);
  initial
  begin
    o_tin = 5'h00;
    o_dir = 5'h00;
    o_cap = 1'b0;
  end

  // ----------------------------------------
  // pulses: idx 0-4 timer pins, 5-9 direction pins, 10 capture pin
  // ----------------------------------------
  // each level held 3 cycles so the synchroniser sees every edge
  task automatic pulse(input int idx, input int n);
    for (int k = 0; k < 2 * n; k++)
    begin
      @(posedge i_clk);
      if (idx < 5)
        o_tin[idx] <= ~o_tin[idx];
      else if (idx < 10)
        o_dir[idx-5] <= ~o_dir[idx-5];
      else
        o_cap <= ~o_cap;
      repeat (2) @(posedge i_clk);
    end
  endtask

  // quadrature pair on timer and direction pin; rev lets B lead
  task automatic quad(input int idx, input int n, input bit rev);
    for (int k = 0; k < 4 * n; k++)
    begin
      @(posedge i_clk);
      if (k[0] ^ rev)
        o_dir[idx] <= ~o_dir[idx];
      else
        o_tin[idx] <= ~o_tin[idx];
      repeat (2) @(posedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

// File: tb/general_purpose_timer_unit_tb.sv
// self-checking bench of the timer unit
`timescale 1ns/100ps
`default_nettype none
module general_purpose_timer_unit_tb;
  import gpt_pkg::*;
  logic i_clk, i_rst, i_wr, i_rd;
  logic [3:0] i_addr;
  logic [15:0] i_wdata, o_rdata, v, r, lfsr;
  logic [4:0] tin, dir;
  logic cap, o_toggle_output_pin, o_core_b_toggle_pin, o_core_b_ovf;
  logic [5:0] o_irq, irq_seen;
  gpt_ctrl_t c;
  int failures, check_count, cycles, t;

  gpt_unit dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer_input_pin(tin),
    .i_direction_input_pin(dir), .i_capture_input_pin(cap),
    .o_toggle_output_pin(o_toggle_output_pin), .o_core_b_toggle_pin(o_core_b_toggle_pin),
    .o_core_b_ovf(o_core_b_ovf), .o_irq(o_irq));
  gpt_pin_model pin_u (.i_clk(i_clk), .o_tin(tin), .o_dir(dir), .o_cap(cap));

  // ----------------------------------------
  // clock, timeout, event capture
  // ----------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    if (!i_rst)
      irq_seen <= irq_seen | o_irq;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      complete_run();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] step(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic wr(input int a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= 4'(a);
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input int a, output logic [15:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= 4'(a);
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata} = {3'b100, 4'h0, 16'h0000};
    {failures, check_count, cycles, irq_seen, lfsr} = {96'h0, 6'h00, 16'h0010};
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    wr(14, 16'hffff);
    for (int a = 0; a < 16; a++)
    begin
      rd(a, v);
      check("reset or unmapped read", 16'h0000, v);
    end
    $display("test reset done");
    for (int g = 0; g < 2; g++)
      for (int s = 0; s < 3; s++)
      begin
        t = g ? 4 : 1;
        c = '0;
        c.presc_sel = 3'(s);
        c.run = 1'b1;
        c.down = s[0];
        wr(t + 5, 16'h8000);
        wr(t, 16'(c));
        rd(t + 5, r);
        repeat (3 * ((g ? 4 : 8) << s) - 2) @(posedge i_clk);
        rd(t + 5, v);
        wr(t, 16'h0000);
        check("prescaled ticks", s[0] ? r - 16'd3 : r + 16'd3, v);
      end
    $display("test prescaler done");
    for (int lvl = 0; lvl < 2; lvl++)
    begin
      c = '0;
      c.mode = GPT_GATED;
      c.gate_lvl = lvl[0];
      c.run = 1'b1;
      wr(1, 16'(c));
      rd(6, r);
      repeat (22) @(posedge i_clk);
      rd(6, v);
      wr(1, 16'h0000);
      check("gated ticks", lvl ? r : r + 16'd3, v);
    end
    $display("test gated done");
    for (int i = 0; i < 3; i++)
    begin
      t = i ? i + 1 : 0;
      lfsr = step(lfsr);
      wr(t + 5, lfsr);
      c = '0;
      c.mode = GPT_COUNTER;
      c.edge_sel = 2'(i + 1);
      c.run = 1'b1;
      wr(t, 16'(c));
      pin_u.pulse(t, 4);
      repeat (6) @(posedge i_clk);
      rd(t + 5, v);
      wr(t, 16'h0000);
      check("event count", lfsr + 16'(i == 2 ? 8 : 4), v);
    end
    $display("test counter done");
    lfsr = step(lfsr);
    wr(5, lfsr);
    wr(0, 16'h0058); // aux_a in encoder mode, running
    pin_u.quad(0, 2, 1'b0);
    repeat (6) @(posedge i_clk);
    rd(5, v);
    check("encoder forward", lfsr + 16'd8, v);
    pin_u.quad(0, 2, 1'b1);
    repeat (6) @(posedge i_clk);
    rd(5, v);
    wr(0, 16'h0000);
    check("encoder reverse", lfsr, v);
    $display("test encoder done");
    c = '0;
    c.run = 1'b1;
    c.tog_en = 1'b1;
    lfsr = step(lfsr);
    r = lfsr & 16'hfff0;
    wr(5, r);
    wr(0, 16'h0020); // aux_a as reload value of core_a
    wr(7, 16'h0000);
    wr(2, 16'h1650); // aux_b counts both edges of core_a latch
    wr(6, 16'hfffd);
    #1 irq_seen = 6'h00;
    wr(1, 16'(c));
    repeat (60) @(posedge i_clk);
    #1 check("core a toggle pin", 16'h0001, {15'h0000, o_toggle_output_pin});
    wr(1, 16'h0000);
    check("core a wrap request", 16'h0002, {10'h000, irq_seen});
    rd(6, v);
    check("core a reload", r, v & 16'hfff0);
    rd(7, v);
    check("aux b latch count", 16'h0001, v);
    $display("test wrap done");
    for (int s = 0; s < 3; s++)
    begin
      lfsr = step(lfsr);
      r = lfsr & 16'hfff0;
      wr(8, r);
      wr(10, 16'h0005 | 16'(s << 3));
      #1 irq_seen = 6'h00;
      pin_u.pulse(s == 0 ? 10 : (s == 1 ? 1 : 6), 1);
      repeat (6) @(posedge i_clk);
      rd(11, v);
      check("captured value", r, v);
      rd(8, v);
      check("aux cleared", 16'h0000, v);
      check("capture request", 16'h0020, {10'h000, irq_seen & 6'h20});
    end
    $display("test capture done");
    wr(10, 16'h0020);
    wr(9, 16'hfffe);
    #1 irq_seen = 6'h00;
    wr(4, 16'(c));
    for (int k = 0; k < 40 && !o_core_b_ovf; k++) @(posedge i_clk);
    #1 check("core b toggle pin", 16'h0001, {15'h0000, o_core_b_toggle_pin});
    wr(4, 16'h0000);
    rd(9, v);
    check("core b reload", r, v & 16'hfffe);
    check("core b wrap request", 16'h0010, {10'h000, irq_seen});
    $display("test reload done");
    complete_run();
  end
endmodule
`default_nettype wire
